/* rtl/ctrl_pkg.sv */
// shared constants and carrier types for the two-wire control target
package ctrl_pkg;
    localparam logic [6:0] TARGET_ADDR = 7'h19;
    localparam logic [7:0] CMD_WRITE = 8'hC0;
    localparam logic [7:0] CMD_READ = 8'h40;
    localparam int NUM_REGS = 6;
    localparam logic [2:0] LAST_INDEX = 3'h5;
    localparam logic [2:0] OFS_POWER = 3'h0;
    localparam logic [2:0] OFS_SPEED = 3'h1;
    localparam logic [2:0] OFS_FORMAT = 3'h2;
    localparam logic [2:0] OFS_MUTE = 3'h3;
    localparam logic [2:0] OFS_LEFT = 3'h4;
    localparam logic [2:0] OFS_RIGHT = 3'h5;
    localparam logic [7:0] RST_POWER = 8'h02;
    localparam logic [7:0] RST_SPEED = 8'h00;
    localparam logic [7:0] RST_FORMAT = 8'h06;
    localparam logic [7:0] RST_MUTE = 8'h01;
    localparam logic [7:0] RST_LEFT = 8'h18;
    localparam logic [7:0] RST_RIGHT = 8'h18;
    localparam int POS_POWER_ON = 1;
    localparam int POS_AUTO_DETECT = 0;
    localparam int POS_SPEED_LO = 1;
    localparam int POS_FORMAT_LO = 0;
    localparam int POS_SLOT_MODE_LO = 3;
    localparam int POS_SLOT_SEL_LO = 5;
    localparam int POS_SYNC = 0;
    localparam int POS_MUTE = 1;
    localparam int POS_RAMP = 2;
    localparam int POS_DELAY = 3;
    localparam int POS_ROLLOFF = 4;
    localparam logic [2:0] RAMP_SLOW_PERIODS = 3'h4;
    localparam logic [2:0] RAMP_FAST_PERIODS = 3'h1;

    typedef struct packed {
        logic converter_power_on;
        logic [1:0] speed_select;
        logic auto_clock_detect;
        logic [2:0] serial_format_select;
        logic [1:0] multislot_format;
        logic multislot_256;
        logic multislot_128;
        logic [1:0] slot_select;
        logic phase_sync_enable;
        logic soft_mute_request;
        logic [2:0] ramp_step_periods;
        logic filter_delay_select;
        logic filter_rolloff_select;
        logic [7:0] left_level_code;
        logic [7:0] right_level_code;
    } dac_ctrl_t;

    typedef struct packed {
        logic we;
        logic [2:0] idx;
        logic [7:0] wdata;
    } reg_wr_t;
endpackage

/* rtl/ctrl_regfile.sv */
// six byte control registers with registered read port
`timescale 1ns/1ps
`default_nettype none
module ctrl_regfile (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic power_down_pin_n,
    input wire ctrl_pkg::reg_wr_t wr,
    input wire logic [2:0] rd_idx,
    output logic [7:0] rd_data,
    output ctrl_pkg::dac_ctrl_t ctrl
);
    typedef struct packed {
        logic [ctrl_pkg::NUM_REGS-1:0][7:0] regs;
        logic [7:0] rd;
    } rf_t;
    rf_t st_r;
    rf_t st_nxt;
    logic [ctrl_pkg::NUM_REGS-1:0][7:0] dflt;

    assign dflt = {ctrl_pkg::RST_RIGHT, ctrl_pkg::RST_LEFT, ctrl_pkg::RST_MUTE,
                   ctrl_pkg::RST_FORMAT, ctrl_pkg::RST_SPEED, ctrl_pkg::RST_POWER};

    always_comb begin
        st_nxt = st_r;
        if (wr.we && wr.idx <= ctrl_pkg::LAST_INDEX) begin
            st_nxt.regs[wr.idx] = wr.wdata;
        end
        if (rd_idx <= ctrl_pkg::LAST_INDEX) begin
            st_nxt.rd = st_nxt.regs[rd_idx];
        end else begin
            st_nxt.rd = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !power_down_pin_n) begin
            st_r <= '{regs: {ctrl_pkg::RST_RIGHT, ctrl_pkg::RST_LEFT, ctrl_pkg::RST_MUTE,
                             ctrl_pkg::RST_FORMAT, ctrl_pkg::RST_SPEED, ctrl_pkg::RST_POWER},
                      rd: 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data = st_r.rd;

    always_comb begin
        logic [7:0] r0;
        logic [7:0] r1;
        logic [7:0] r2;
        logic [7:0] r3;
        r0 = st_r.regs[ctrl_pkg::OFS_POWER];
        r1 = st_r.regs[ctrl_pkg::OFS_SPEED];
        r2 = st_r.regs[ctrl_pkg::OFS_FORMAT];
        r3 = st_r.regs[ctrl_pkg::OFS_MUTE];
        ctrl.converter_power_on = r0[ctrl_pkg::POS_POWER_ON];
        ctrl.auto_clock_detect = r1[ctrl_pkg::POS_AUTO_DETECT];
        ctrl.speed_select = r1[ctrl_pkg::POS_AUTO_DETECT] ? 2'h0
                          : r1[ctrl_pkg::POS_SPEED_LO +: 2];
        ctrl.serial_format_select = r2[ctrl_pkg::POS_FORMAT_LO +: 3];
        ctrl.multislot_format = r2[ctrl_pkg::POS_SLOT_MODE_LO +: 2];
        ctrl.multislot_256 = r2[ctrl_pkg::POS_SLOT_MODE_LO + 1];
        ctrl.multislot_128 = (r2[ctrl_pkg::POS_SLOT_MODE_LO +: 2] == 2'h1);
        ctrl.slot_select = r2[ctrl_pkg::POS_SLOT_SEL_LO +: 2];
        ctrl.phase_sync_enable = r3[ctrl_pkg::POS_SYNC];
        ctrl.soft_mute_request = r3[ctrl_pkg::POS_MUTE];
        ctrl.ramp_step_periods = r3[ctrl_pkg::POS_RAMP] ? ctrl_pkg::RAMP_SLOW_PERIODS
                               : ctrl_pkg::RAMP_FAST_PERIODS;
        ctrl.filter_delay_select = r3[ctrl_pkg::POS_DELAY];
        ctrl.filter_rolloff_select = r3[ctrl_pkg::POS_ROLLOFF];
        ctrl.left_level_code = st_r.regs[ctrl_pkg::OFS_LEFT];
        ctrl.right_level_code = st_r.regs[ctrl_pkg::OFS_RIGHT];
    end

    // default set wins one cycle after pin low
    chk_pin_defaults: assert property (@(posedge clk) disable iff (sys_rst)
        !power_down_pin_n |=> st_r.regs == dflt)
        else $error("registers not at defaults after power-down pin low");
    chk_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
        (power_down_pin_n && wr.we && wr.idx <= ctrl_pkg::LAST_INDEX)
        ##1 power_down_pin_n |-> st_r.regs[$past(wr.idx)] == $past(wr.wdata))
        else $error("written byte not stored");
    chk_auto_masks: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl.auto_clock_detect |-> ctrl.speed_select == 2'h0)
        else $error("speed bits not ignored in auto detect");
endmodule // ctrl_regfile
`default_nettype wire

/* rtl/dac_i2c_control_regs.sv */
// two-wire control target for the stereo converter
//
// Operation
// - ack address only if it matches
// - address lsb zero writes, one reads
// - two sub-address bytes, low three bits
// - data bytes stored to addressed register
// - ack every received byte
// - index increments, wraps after five
// - start and stop framing
// - data changes only while clock low
// - repeated start read returns addressed register
// - controller ack advances read index
// - power-down pin restores defaults
// - power bit powers converter
// - auto detect overrides speed bits
// - format field resets to 110b
// - multislot field decodes three modes
// - soft mute and sync enable
// - ramp rate one or four periods
`timescale 1ns/1ps
`default_nettype none
module dac_i2c_control_regs (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic power_down_pin_n,
    input wire logic bus_speed_pin,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic fast_plus_mode,
    output ctrl_pkg::dac_ctrl_t ctrl
);
    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [7:0] shift;
        logic [3:0] bitcnt;
        logic [2:0] bytecnt;
        logic [2:0] idx;
        logic rd_dir;
        logic drive_low;
        logic tx_bit;
        logic speed;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic scl;
    logic scl_rose;
    logic scl_fell;
    logic sda;
    logic sda_rose;
    logic sda_fell;
    logic [7:0] rd_data;
    ctrl_pkg::reg_wr_t wr;

    line_sampler u_scl (
        .clk(clk),
        .sys_rst(sys_rst),
        .line_in(scl_in),
        .level(scl),
        .rose(scl_rose),
        .fell(scl_fell)
    );

    line_sampler u_sda (
        .clk(clk),
        .sys_rst(sys_rst),
        .line_in(sda_in),
        .level(sda),
        .rose(sda_rose),
        .fell(sda_fell)
    );

    ctrl_regfile u_regs (
        .clk(clk),
        .sys_rst(sys_rst),
        .power_down_pin_n(power_down_pin_n),
        .wr(wr),
        .rd_idx(st_r.idx),
        .rd_data(rd_data),
        .ctrl(ctrl)
    );

    function automatic logic [2:0] next_index(input logic [2:0] i);
        next_index = (i >= ctrl_pkg::LAST_INDEX) ? 3'h0 : 3'(i + 3'h1);
    endfunction

    logic start_cond;
    logic stop_cond;
    logic [7:0] rx_byte;

    assign start_cond = scl && sda_fell;
    assign stop_cond = scl && sda_rose;
    assign rx_byte = {st_r.shift[6:0], sda};

    always_comb begin
        st_nxt = st_r;
        wr = '{we: 1'b0, idx: st_r.idx, wdata: rx_byte};
        // the speed pin only latches while powered down; it tunes no filter here
        // speed pin captured in power-down
        if (!power_down_pin_n) begin
            st_nxt.speed = bus_speed_pin;
        end
        if (!power_down_pin_n) begin
            st_nxt.phase = ST_IDLE;
            st_nxt.drive_low = 1'b0;
            st_nxt.idx = 3'h0;
        end else if (start_cond) begin
            st_nxt.phase = ST_ADDR;
            st_nxt.bitcnt = 4'h0;
            st_nxt.drive_low = 1'b0;
        end else if (stop_cond) begin
            st_nxt.phase = ST_IDLE;
            st_nxt.drive_low = 1'b0;
        end else begin
            case (st_r.phase)
                ST_IDLE: begin
                    st_nxt.drive_low = 1'b0;
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rose) begin
                        st_nxt.shift = rx_byte;
                        st_nxt.bitcnt = 4'(st_r.bitcnt + 4'h1);
                    end else if (scl_fell && st_r.bitcnt == 4'h8) begin
                        st_nxt.bitcnt = 4'h0;
                        if (st_r.phase == ST_ADDR) begin
                            if (st_r.shift[7:1] == ctrl_pkg::TARGET_ADDR) begin
                                st_nxt.rd_dir = st_r.shift[0];
                                st_nxt.bytecnt = 3'h0;
                                st_nxt.phase = ST_ADDR_ACK;
                                st_nxt.drive_low = 1'b1;
                            end else begin
                                st_nxt.phase = ST_IDLE;
                            end
                        end else begin
                            st_nxt.phase = ST_RX_ACK;
                            st_nxt.drive_low = 1'b1;
                            // command byte is skipped, both codes accepted
                            if (st_r.bytecnt == 3'h2) begin
                                // only low three sub-address bits count
                                st_nxt.idx = st_r.shift[2:0];
                            end
                            if (st_r.bytecnt >= 3'h3) begin
                                wr.we = 1'b1;
                                wr.wdata = st_r.shift;
                                st_nxt.idx = next_index(st_r.idx);
                            end
                            if (st_r.bytecnt < 3'h3) begin
                                st_nxt.bytecnt = 3'(st_r.bytecnt + 3'h1);
                            end
                        end
                    end
                end
                ST_ADDR_ACK, ST_RX_ACK: begin
                    if (scl_fell) begin
                        st_nxt.drive_low = 1'b0;
                        if (st_r.phase == ST_ADDR_ACK && st_r.rd_dir) begin
                            st_nxt.phase = ST_TX;
                            st_nxt.shift = rd_data;
                            st_nxt.tx_bit = rd_data[7];
                            st_nxt.bitcnt = 4'h1;
                            st_nxt.drive_low = ~rd_data[7];
                        end else begin
                            st_nxt.phase = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fell) begin
                        if (st_r.bitcnt == 4'h8) begin
                            st_nxt.phase = ST_TX_ACK;
                            st_nxt.drive_low = 1'b0;
                        end else begin
                            st_nxt.tx_bit = st_r.shift[3'(4'h7 - st_r.bitcnt)];
                            st_nxt.drive_low = ~st_r.shift[3'(4'h7 - st_r.bitcnt)];
                            st_nxt.bitcnt = 4'(st_r.bitcnt + 4'h1);
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rose) begin
                        // ack advances, nack ends the read
                        if (!sda) begin
                            st_nxt.idx = next_index(st_r.idx);
                            st_nxt.bitcnt = 4'h0;
                        end else begin
                            st_nxt.phase = ST_IDLE;
                        end
                    end else if (scl_fell && st_r.bitcnt == 4'h0) begin
                        // read port registered one cycle after index moved
                        st_nxt.phase = ST_TX;
                        st_nxt.shift = rd_data;
                        st_nxt.tx_bit = rd_data[7];
                        st_nxt.bitcnt = 4'h1;
                        st_nxt.drive_low = ~rd_data[7];
                    end
                end
                default: begin
                    st_nxt.phase = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '{phase: ST_IDLE, shift: 8'h00, bitcnt: 4'h0, bytecnt: 3'h0,
                      idx: 3'h0, rd_dir: 1'b0, drive_low: 1'b0, tx_bit: 1'b1,
                      speed: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = st_r.drive_low;
    assign fast_plus_mode = st_r.speed;

    // foreign address: line left alone until the next start
    chk_addr_ack: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.phase == ST_ADDR && scl_fell && st_r.bitcnt == 4'h8 && !start_cond
         && !stop_cond && power_down_pin_n && st_r.shift[7:1] != ctrl_pkg::TARGET_ADDR)
        |=> st_r.phase == ST_IDLE && !sda_oe)
        else $error("foreign address acknowledged");

    chk_idle_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.phase == ST_IDLE |-> !sda_oe)
        else $error("line pulled while idle");

    chk_dir_latch: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.phase == ST_ADDR && scl_fell && st_r.bitcnt == 4'h8 && !start_cond
         && !stop_cond && power_down_pin_n && st_r.shift[7:1] == ctrl_pkg::TARGET_ADDR)
        |=> st_r.phase == ST_ADDR_ACK && st_r.rd_dir == $past(st_r.shift[0]))
        else $error("direction bit not latched");

    chk_sub_index: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.phase == ST_RX && scl_fell && st_r.bitcnt == 4'h8 && st_r.bytecnt == 3'h2
         && !start_cond && !stop_cond && power_down_pin_n)
        |=> st_r.idx == $past(st_r.shift[2:0]))
        else $error("sub-address low bits not taken as index");

    chk_ack_drive: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.phase == ST_RX_ACK || st_r.phase == ST_ADDR_ACK) |-> sda_oe)
        else $error("ack slot not driven low");

    chk_rx_release: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.phase == ST_RX_ACK && scl_fell && !start_cond && !stop_cond && power_down_pin_n)
        |=> st_r.phase == ST_RX && !sda_oe)
        else $error("ack not released after ninth clock");

    chk_index_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        (wr.we && st_r.idx == ctrl_pkg::LAST_INDEX && power_down_pin_n)
        |=> st_r.idx == 3'h0)
        else $error("index did not wrap to zero");

    chk_write_step: assert property (@(posedge clk) disable iff (sys_rst)
        (wr.we && st_r.idx < ctrl_pkg::LAST_INDEX && power_down_pin_n)
        |=> st_r.idx == 3'($past(st_r.idx) + 3'h1))
        else $error("index did not step after write");

    chk_start_addr: assert property (@(posedge clk) disable iff (sys_rst)
        (start_cond && power_down_pin_n) |=> st_r.phase == ST_ADDR && st_r.bitcnt == 4'h0)
        else $error("start did not open address phase");

    chk_stop_idle: assert property (@(posedge clk) disable iff (sys_rst)
        (stop_cond && !start_cond) |=> st_r.phase == ST_IDLE)
        else $error("stop did not end transfer");

    // bits are taken on a sampled clock rise only
    chk_bit_sample: assert property (@(posedge clk) disable iff (sys_rst)
        ((st_r.phase == ST_ADDR || st_r.phase == ST_RX) && scl_rose && !start_cond
         && !stop_cond && power_down_pin_n) |=> st_r.shift == $past(rx_byte))
        else $error("received bit not shifted in");

    // read bits move one clock after a sampled fall, never under a high clock
    chk_stable_high: assert property (@(posedge clk) disable iff (sys_rst)
        (scl && $stable(scl) && st_r.phase == ST_TX) |-> $stable(sda_oe))
        else $error("data changed while clock high");

    chk_tx_first: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.phase == ST_ADDR_ACK && st_r.rd_dir && scl_fell && power_down_pin_n
         && !start_cond && !stop_cond) |=> sda_oe == ~$past(rd_data[7]))
        else $error("read byte msb not presented");

    chk_tx_level: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.phase == ST_TX |-> sda_oe == ~st_r.tx_bit)
        else $error("line does not follow the bit being sent");

    chk_read_adv: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.phase == ST_TX_ACK && scl_rose && !sda && power_down_pin_n && !stop_cond
         && !start_cond) |=> st_r.idx == next_index($past(st_r.idx)))
        else $error("read index did not advance on ack");

    chk_nack_ends: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.phase == ST_TX_ACK && scl_rose && sda && power_down_pin_n && !stop_cond
         && !start_cond) |=> st_r.phase == ST_IDLE && !sda_oe)
        else $error("read went on after a nack");

    chk_pdn_release: assert property (@(posedge clk) disable iff (sys_rst)
        !power_down_pin_n |=> !sda_oe)
        else $error("line still pulled in power-down");

    chk_pdn_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !power_down_pin_n |=> st_r.phase == ST_IDLE ##1 ctrl.converter_power_on)
        else $error("power-down did not idle and restore power bit");

    // the speed copy only moves while powered down
    chk_speed_hold: assert property (@(posedge clk) disable iff (sys_rst)
        power_down_pin_n |=> $stable(fast_plus_mode))
        else $error("bus speed changed in operation");

    cov_write: cover property (@(posedge clk) wr.we);
    cov_read: cover property (@(posedge clk) st_r.phase == ST_TX_ACK && scl_rose && !sda);
    cov_wrap: cover property (@(posedge clk) wr.we && st_r.idx == ctrl_pkg::LAST_INDEX);
    cov_foreign: cover property (@(posedge clk) st_r.phase == ST_ADDR && scl_fell
        && st_r.bitcnt == 4'h8 && st_r.shift[7:1] != ctrl_pkg::TARGET_ADDR);
    cov_power_down: cover property (@(posedge clk) !power_down_pin_n && st_r.speed);
endmodule // dac_i2c_control_regs
`default_nettype wire

/* rtl/line_sampler.sv */
// edge and level filter for one open-drain line
`timescale 1ns/1ps
`default_nettype none
module line_sampler (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic line_in,
    output logic level,
    output logic rose,
    output logic fell
);
    typedef struct packed {
        logic cur;
        logic prev;
    } samp_t;
    samp_t st_r;
    samp_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = st_r.cur;
        st_nxt.cur = line_in;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '{cur: 1'b1, prev: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.cur;
    assign rose = st_r.cur & ~st_r.prev;
    assign fell = ~st_r.cur & st_r.prev;
endmodule // line_sampler
`default_nettype wire

/* tb/dac_i2c_control_regs_tb.sv */
// self-checking bench for the two-wire control target
`timescale 1ns/1ps
`default_nettype none
module dac_i2c_control_regs_tb;
    localparam int LIMIT = 40000;
    localparam logic [7:0] MASK [6] = '{8'h02, 8'h07, 8'h7F, 8'h1F, 8'hFF, 8'hFF};
    logic clk;
    logic sys_rst;
    logic power_down_pin_n;
    logic bus_speed_pin;
    logic scl;
    logic host_low;
    logic sda_out;
    logic sda_oe;
    logic fast_plus_mode;
    ctrl_pkg::dac_ctrl_t ctrl;
    wire logic sda_line;
    logic [7:0] exp [6];
    int seed = 32'h7D77A3BF;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int mode_k = 0;

    // pulled up: low whenever either party pulls
    assign sda_line = ~(host_low | (sda_oe & ~sda_out));

    dac_i2c_control_regs u_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .power_down_pin_n(power_down_pin_n),
        .bus_speed_pin(bus_speed_pin),
        .scl_in(scl),
        .sda_in(sda_line),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .fast_plus_mode(fast_plus_mode),
        .ctrl(ctrl)
    );

    i2c_host_model u_host (
        .clk(clk),
        .sda_line(sda_line),
        .scl(scl),
        .sda_low(host_low)
    );

    always #10 clk = ~clk;

    task automatic test_done();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            mismatches = mismatches + 1;
            test_done();
        end
    end

    task automatic cmp(input logic [63:0] seen, input logic [63:0] want);
        compares = compares + 1;
        if (seen !== want) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    function automatic logic [2:0] next_idx(input logic [2:0] i);
        return (i == 3'h5) ? 3'h0 : i + 3'h1;
    endfunction

    task automatic send(input logic [7:0] d, input logic want);
        logic ack;
        u_host.wbyte(d, ack);
        cmp(64'(ack), 64'(want));
    endtask

    task automatic wr_burst(input logic [6:0] a, input logic [2:0] idx, input int n);
        logic [7:0] d;
        logic [2:0] i;
        i = idx;
        u_host.start();
        send({a, 1'b0}, a == ctrl_pkg::TARGET_ADDR);
        if (a != ctrl_pkg::TARGET_ADDR) begin
            send(ctrl_pkg::CMD_WRITE, 1'b0);
        end else begin
            send(ctrl_pkg::CMD_WRITE, 1'b1);
            send(8'h00, 1'b1);
            send({5'h00, idx}, 1'b1);
            for (int k = 0; k < n; k++) begin
                d = 8'($random(seed)) & MASK[i];
                if (i == 3'h1) d[0] = mode_k[0];
                if (i == 3'h2) d[4:3] = 2'(mode_k);
                if (i == 3'h3) d[2:1] = 2'(mode_k);
                send(d, 1'b1);
                exp[i] = d;
                // wrap keeps writes below index six
                i = next_idx(i);
            end
        end
        u_host.stop();
    endtask

    task automatic rd_burst(input logic [2:0] idx, input int n);
        logic [7:0] d;
        logic [2:0] i;
        i = idx;
        u_host.start();
        send({ctrl_pkg::TARGET_ADDR, 1'b0}, 1'b1);
        send(ctrl_pkg::CMD_READ, 1'b1);
        send(8'h00, 1'b1);
        send({5'h00, idx}, 1'b1);
        u_host.start();
        send({ctrl_pkg::TARGET_ADDR, 1'b1}, 1'b1);
        for (int k = 0; k < n; k++) begin
            u_host.rbyte(k != n - 1, d);
            cmp(64'(d), 64'(exp[i]));
            i = next_idx(i);
        end
        u_host.stop();
    endtask

    task automatic check_ctrl();
        ctrl_pkg::dac_ctrl_t e;
        e.converter_power_on = exp[0][1];
        e.auto_clock_detect = exp[1][0];
        // auto detect hides the speed bits
        e.speed_select = exp[1][0] ? 2'h0 : exp[1][2:1];
        e.serial_format_select = exp[2][2:0];
        e.multislot_format = exp[2][4:3];
        // two and three both pick 256-clock slots
        e.multislot_256 = exp[2][4];
        e.multislot_128 = (exp[2][4:3] == 2'h1);
        e.slot_select = exp[2][6:5];
        e.phase_sync_enable = exp[3][0];
        e.soft_mute_request = exp[3][1];
        // ramp step one or four periods
        e.ramp_step_periods = exp[3][2] ? 3'h4 : 3'h1;
        e.filter_delay_select = exp[3][3];
        e.filter_rolloff_select = exp[3][4];
        e.left_level_code = exp[4];
        e.right_level_code = exp[5];
        cmp(64'(ctrl), 64'(e));
    endtask

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        power_down_pin_n = 1'b1;
        bus_speed_pin = 1'b0;
        exp = '{8'h02, 8'h00, 8'h06, 8'h01, 8'h18, 8'h18};
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        check_ctrl();
        cmp(64'(ctrl.serial_format_select), 64'(3'h6));
        cmp(64'(fast_plus_mode), 64'h0);
        rd_burst(3'h0, 7);
        wr_burst(7'h1A, 3'h0, 1);
        // each pass walks a new slot and mute/ramp mode and toggles auto detect
        for (int k = 0; k < 4; k++) begin
            mode_k = k;
            wr_burst(ctrl_pkg::TARGET_ADDR, 3'(k + 2), 8);
            check_ctrl();
            rd_burst(3'(5 - k), 7);
        end
        // speed pin moves only while powered down
        @(posedge clk);
        power_down_pin_n <= 1'b0;
        bus_speed_pin <= 1'b1;
        repeat (3) @(posedge clk);
        power_down_pin_n <= 1'b1;
        repeat (4) @(posedge clk);
        exp = '{8'h02, 8'h00, 8'h06, 8'h01, 8'h18, 8'h18};
        check_ctrl();
        cmp(64'(fast_plus_mode), 64'h1);
        rd_burst(3'h4, 3);
        test_done();
    end
endmodule // dac_i2c_control_regs_tb
`default_nettype wire

/* tb/i2c_host_model.sv */
// two-wire bus controller model that drives the target from the host side
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    input wire logic clk,
    input wire logic sda_line,
    output var logic scl,
    output var logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // start with clock high
    // long lead-in so a target still holding its ack has let go first
    task automatic start();
        tick(1);
        sda_low <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask

    task automatic stop();
        tick(1);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(4);
    endtask

    // data moves only while clock low
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        sda_low <= ~b;
        tick(4);
        scl <= 1'b1;
        tick(4);
        r = sda_line;
        scl <= 1'b0;
    endtask

    // msb first, ack seen in the ninth slot
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // a nack on the last byte ends the read
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule // i2c_host_model
`default_nettype wire
